// ---- rtl/dim_link_pkg.sv ----
// Package with timing constants and widths for the single-wire dimming link.
package dim_link_pkg;
  localparam int          CLK_MHZ        = 200;
  localparam int          CODE_WIDTH     = 5;
  localparam int          ONE_MIN_US     = 15;
  localparam int          ONE_MAX_US     = 45;
  localparam int          ZERO_MIN_US    = 90;
  localparam int          ZERO_MAX_US    = 120;
  localparam int          LOAD_MIN_US    = 215;
  localparam int          HIGH_MIN_US    = 3;
  localparam int          ONE_MIN_CYC    = ONE_MIN_US * CLK_MHZ;
  localparam int          ONE_MAX_CYC    = ONE_MAX_US * CLK_MHZ;
  localparam int          ZERO_MIN_CYC   = ZERO_MIN_US * CLK_MHZ;
  localparam int          ZERO_MAX_CYC   = ZERO_MAX_US * CLK_MHZ;
  localparam int          LOAD_MIN_CYC   = LOAD_MIN_US * CLK_MHZ;
  localparam int          HIGH_MIN_CYC   = HIGH_MIN_US * CLK_MHZ;
  localparam int          CNT_WIDTH      = 17;
  localparam logic [4:0]  CODE_RESET     = 5'h00;
  // Host pulse targets, inside each valid window and short to keep frames brief.
  localparam int          ONE_TGT_US     = 20;
  localparam int          ZERO_TGT_US    = 95;
  localparam int          LOAD_TGT_US    = 220;
  localparam int          GAP_TGT_US     = 5;
  localparam int          ONE_TGT_CYC    = ONE_TGT_US * CLK_MHZ;
  localparam int          ZERO_TGT_CYC   = ZERO_TGT_US * CLK_MHZ;
  localparam int          LOAD_TGT_CYC   = LOAD_TGT_US * CLK_MHZ;
  localparam int          GAP_TGT_CYC    = GAP_TGT_US * CLK_MHZ;
endpackage : dim_link_pkg

// ---- rtl/dim_link_if.sv ----
// Interface carrying the open-drain dimming line and the enable pin.
`timescale 1ns/100ps
interface dim_link_if;
  logic serial_dim_out;
  logic serial_dim_oe;
  logic serial_dim_in;
  logic enable;
  assign serial_dim_in = serial_dim_oe ? serial_dim_out : 1'b1;
  modport host_end (
    output serial_dim_out,
    output serial_dim_oe,
    output enable,
    input  serial_dim_in
  );
  modport device_end (
    input serial_dim_in,
    input enable
  );
endinterface : dim_link_if

// ---- rtl/dim_host.sv ----
// Host end that sends a 5-bit brightness code and a load pulse.
`timescale 1ns/100ps
module dim_host
  import dim_link_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  dim_link_if.host_end                       link,
  input  wire logic                          enable_req,
  input  wire logic                          send_valid,
  input  wire logic [dim_link_pkg::CODE_WIDTH-1:0] send_code,
  output logic                               send_ready
);
  import dim_link_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_GAP} host_state_type;

  host_state_type        state_reg;
  logic [CNT_WIDTH-1:0]  cnt_reg;
  logic [CNT_WIDTH-1:0]  low_len_reg;
  logic [CODE_WIDTH-1:0] code_reg;
  logic [2:0]            idx_reg;
  logic                  oe_reg;
  logic                  en_reg;

  assign link.serial_dim_out = 1'b0;
  assign link.serial_dim_oe  = oe_reg;
  assign link.enable         = en_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= enable_req; // [R8]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || !en_reg) begin
      state_reg   <= H_IDLE;
      cnt_reg     <= '0;
      low_len_reg <= '0;
      code_reg    <= '0;
      idx_reg     <= '0;
      oe_reg      <= 1'b0; // [R5]
      send_ready  <= 1'b0;
    end else begin
      unique case (state_reg)
        H_IDLE: begin
          send_ready <= 1'b1;
          oe_reg     <= 1'b0;
          if (send_valid && send_ready) begin
            send_ready  <= 1'b0;
            code_reg    <= send_code;
            idx_reg     <= 3'h0;
            cnt_reg     <= '0;
            oe_reg      <= 1'b1;
            state_reg   <= H_LOW;
            low_len_reg <= send_code[CODE_WIDTH-1] ?
                           CNT_WIDTH'(ONE_TGT_CYC) :
                           CNT_WIDTH'(ZERO_TGT_CYC); // [R1] [R2]
          end
        end
        H_LOW: begin
          if (cnt_reg == low_len_reg - 1'b1) begin
            oe_reg    <= 1'b0; // [R5]
            cnt_reg   <= '0;
            state_reg <= H_GAP;
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
        H_GAP: begin
          if (cnt_reg == CNT_WIDTH'(GAP_TGT_CYC - 1)) begin // [R4]
            cnt_reg <= '0;
            if (idx_reg == 3'h5) begin
              state_reg <= H_IDLE;
            end else begin
              idx_reg   <= idx_reg + 3'h1;
              code_reg  <= {code_reg[CODE_WIDTH-2:0], 1'b0};
              oe_reg    <= 1'b1;
              state_reg <= H_LOW;
              if (idx_reg == 3'h4) begin
                low_len_reg <= CNT_WIDTH'(LOAD_TGT_CYC); // [R3]
              end else begin
                low_len_reg <= code_reg[CODE_WIDTH-2] ?
                               CNT_WIDTH'(ONE_TGT_CYC) :
                               CNT_WIDTH'(ZERO_TGT_CYC); // [R1] [R2]
              end
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end
endmodule : dim_host

// ---- rtl/dim_device.sv ----
// Device end: pulse decoder, brightness register and overvoltage gate.
`timescale 1ns/100ps
// Operation
// R1 - Low 15 to 45 us decodes one
// R2 - Low 90 to 120 us decodes zero
// R3 - Low over 215 us loads five bits
// R4 - Host keeps line high at least 3 us
// R5 - Line idles high, host only pulls low
// R6 - Brightness is 5-bit code, linear levels
// R7 - Disable or lockout clears interface and code
// R8 - Enable low powers down, host reprograms
// R9 - Overvoltage stops switching until hysteresis release
// R10 - Overvoltage never shuts down nor alters code
// R11 - Earliest of five bits becomes MSB
// R12 - Out-of-range pulses are ignored entirely
module dim_device
  import dim_link_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  dim_link_if.device_end                     link,
  input  wire logic                          undervoltage_lockout,
  input  wire logic                          overvoltage_trip,
  input  wire logic                          overvoltage_clear,
  output logic [dim_link_pkg::CODE_WIDTH-1:0] brightness_code,
  output logic                               boost_switch_enable,
  output logic                               powered_on
);
  import dim_link_pkg::*;

  localparam int SAT = LOAD_MIN_CYC + 1;

  typedef enum logic [1:0] {
    LINE_OFF,
    LINE_HIGH,
    LINE_LOW
  } line_state_type;

  typedef enum logic {
    BOOST_RUN,
    BOOST_HOLD
  } boost_state_type;

  line_state_type        line_state_reg;
  boost_state_type       boost_state_reg;
  logic                  off;
  logic                  rise;
  logic [CNT_WIDTH-1:0]  low_cnt_reg;
  logic                  low_sat;
  logic                  above_one_min;
  logic                  below_one_max;
  logic                  above_zero_min;
  logic                  below_zero_max;
  logic                  above_load_min;
  logic                  is_one;
  logic                  is_zero;
  logic                  is_load;
  logic                  shift_en;
  logic                  load_en;
  logic [CODE_WIDTH-1:0] shift_reg;
  logic [CODE_WIDTH-1:0] shift_next;
  logic                  boost_hold;

  assign off     = rst || !link.enable || undervoltage_lockout; // [R7] [R8]
  assign rise    = (line_state_reg == LINE_LOW) && link.serial_dim_in;
  assign low_sat = (low_cnt_reg == CNT_WIDTH'(SAT));

  // A pulse already low when the device wakes is not counted.
  always_ff @(posedge clk_sys) begin
    if (off) begin
      line_state_reg <= LINE_OFF;
    end else begin
      unique case (line_state_reg)
        LINE_OFF: begin
          if (link.serial_dim_in) begin
            line_state_reg <= LINE_HIGH; // [R5]
          end
        end
        LINE_HIGH: begin
          if (!link.serial_dim_in) begin
            line_state_reg <= LINE_LOW;
          end
        end
        LINE_LOW: begin
          if (link.serial_dim_in) begin
            line_state_reg <= LINE_HIGH;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      low_cnt_reg <= '0;
    end else if (link.serial_dim_in) begin
      low_cnt_reg <= '0; // [R5]
    end else if (!low_sat) begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // Bounds are strict, so a width right on a limit decodes as nothing.
  assign above_one_min  = low_cnt_reg > CNT_WIDTH'(ONE_MIN_CYC);
  assign below_one_max  = low_cnt_reg < CNT_WIDTH'(ONE_MAX_CYC);
  assign above_zero_min = low_cnt_reg > CNT_WIDTH'(ZERO_MIN_CYC);
  assign below_zero_max = low_cnt_reg < CNT_WIDTH'(ZERO_MAX_CYC);
  assign above_load_min = low_cnt_reg > CNT_WIDTH'(LOAD_MIN_CYC);
  assign is_one         = above_one_min && below_one_max; // [R1]
  assign is_zero        = above_zero_min && below_zero_max; // [R2]
  assign is_load        = above_load_min; // [R3]

  // Any other width leaves both registers untouched. [R12]
  assign shift_en   = rise && (is_one || is_zero);
  assign load_en    = rise && is_load;
  assign shift_next = {shift_reg[CODE_WIDTH-2:0], is_one}; // [R11]

  for (genvar i = 0; i < CODE_WIDTH; i++) begin : g_shift
    always_ff @(posedge clk_sys) begin
      if (off) begin
        shift_reg[i] <= CODE_RESET[i]; // [R7]
      end else if (shift_en) begin
        shift_reg[i] <= shift_next[i]; // [R1] [R2]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      brightness_code <= CODE_RESET; // [R7]
    end else if (load_en) begin
      brightness_code <= shift_reg; // [R3] [R6]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (off) begin
      boost_state_reg <= BOOST_RUN;
    end else begin
      unique case (boost_state_reg)
        BOOST_RUN: begin
          if (overvoltage_trip) begin
            boost_state_reg <= BOOST_HOLD; // [R9]
          end
        end
        BOOST_HOLD: begin
          if (!overvoltage_trip && overvoltage_clear) begin
            boost_state_reg <= BOOST_RUN; // [R9]
          end
        end
      endcase
    end
  end

  // The trip input wins over a clear that arrives in the same cycle.
  assign boost_hold = overvoltage_trip ||
                      (boost_state_reg == BOOST_HOLD && !overvoltage_clear);

  always_ff @(posedge clk_sys) begin
    if (off) begin
      boost_switch_enable <= 1'b0; // [R7]
    end else begin
      boost_switch_enable <= !boost_hold; // [R9]
    end
  end

  // Overvoltage never reaches this flop, so it cannot power down. [R10]
  always_ff @(posedge clk_sys) begin
    if (off) begin
      powered_on <= 1'b0; // [R8]
    end else begin
      powered_on <= 1'b1; // [R10]
    end
  end
endmodule : dim_device

// ---- dv/dim_link_assertions.sv ----
// Checker for the dimming link and the device outputs.
`timescale 1ns/100ps
module dim_link_assertions (
  input wire logic                           clk_sys,
  input wire logic                           rst,
  input wire logic                           serial_dim_oe,
  input wire logic                           serial_dim_in,
  input wire logic                           enable,
  input wire logic                           undervoltage_lockout,
  input wire logic                           overvoltage_trip,
  input wire logic                           overvoltage_clear,
  input wire logic [dim_link_pkg::CODE_WIDTH-1:0] brightness_code,
  input wire logic                           boost_switch_enable
);
  import dim_link_pkg::*;
  logic [16:0] low_cnt;
  logic        in_q;
  logic        rose_q;
  logic [16:0] high_cnt;
  always_ff @(posedge clk_sys) begin
    low_cnt <= serial_dim_oe ? low_cnt + 17'h1 : 17'h0;
  end
  always_ff @(posedge clk_sys) begin
    in_q <= serial_dim_in;
    rose_q <= serial_dim_in & ~in_q;
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      high_cnt <= 17'(HIGH_MIN_CYC);
    end else if (serial_dim_oe) begin
      high_cnt <= 17'h0;
    end else if (high_cnt < 17'(HIGH_MIN_CYC)) begin
      high_cnt <= high_cnt + 17'h1;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_on;
    enable && !undervoltage_lockout;
  endsequence
  sequence s_trip;
    overvoltage_trip && !$rose(serial_dim_in) ##0 s_on;
  endsequence
  chk_pulse_width: assert property ($fell(serial_dim_oe) |->
    (low_cnt > ONE_MIN_CYC && low_cnt < ONE_MAX_CYC) ||
    (low_cnt > ZERO_MIN_CYC && low_cnt < ZERO_MAX_CYC) ||
    low_cnt > LOAD_MIN_CYC) else $error("pulse width out of range");
  chk_gap_high: assert property ($fell(serial_dim_oe) |->
    !serial_dim_oe [*8]) else $error("high gap too short");
  chk_gap_count: assert property ($rose(serial_dim_oe) |->
    high_cnt >= 17'(HIGH_MIN_CYC)) else $error("high gap below minimum");
  chk_idle_high: assert property (!serial_dim_oe |-> serial_dim_in)
    else $error("released line not high");
  chk_off_clears: assert property (!enable || undervoltage_lockout |=>
    brightness_code == 5'h00 && !boost_switch_enable) else $error("not cleared");
  chk_ovp_stop: assert property (s_trip |=> !boost_switch_enable)
    else $error("switching during overvoltage");
  chk_ovp_hold: assert property (!boost_switch_enable &&
    !overvoltage_clear ##1 s_on |-> !boost_switch_enable)
    else $error("switching before hysteresis release");
  chk_ovp_code: assert property (s_trip ##1 s_on |->
    $stable(brightness_code)) else $error("overvoltage changed code");
  chk_code_cause: assert property ($changed(brightness_code) |->
    rose_q || !$past(enable) || $past(undervoltage_lockout))
    else $error("code changed without load");
endmodule : dim_link_assertions

// ---- dv/testbench.sv ----
// Self-checking bench joining host and device across the link.
`timescale 1ns/100ps
module testbench;
  import dim_link_pkg::*;
  logic       clk_sys = 1'b0;
  logic       rst = 1'b1;
  logic       enable_req = 1'b1;
  logic       send_valid = 1'b0;
  logic [4:0] send_code = 5'h00;
  logic       undervoltage_lockout = 1'b0;
  logic       overvoltage_trip = 1'b0;
  logic       overvoltage_clear = 1'b1;
  logic       send_ready;
  logic [4:0] brightness_code;
  logic       boost_switch_enable;
  logic       powered_on;
  int         err_total = 0;
  int         num_checks = 0;
  always #2.5 clk_sys = ~clk_sys;
  dim_link_if dim_link_if_i ();
  dim_host dim_host_i (.clk_sys(clk_sys), .rst(rst), .link(dim_link_if_i),
    .enable_req(enable_req), .send_valid(send_valid),
    .send_code(send_code), .send_ready(send_ready));
  dim_device dim_device_i (.clk_sys(clk_sys), .rst(rst),
    .link(dim_link_if_i), .undervoltage_lockout(undervoltage_lockout),
    .overvoltage_trip(overvoltage_trip),
    .overvoltage_clear(overvoltage_clear),
    .brightness_code(brightness_code),
    .boost_switch_enable(boost_switch_enable), .powered_on(powered_on));
  dim_link_assertions dim_link_assertions_i (.clk_sys(clk_sys), .rst(rst),
    .serial_dim_oe(dim_link_if_i.serial_dim_oe),
    .serial_dim_in(dim_link_if_i.serial_dim_in),
    .enable(dim_link_if_i.enable),
    .undervoltage_lockout(undervoltage_lockout),
    .overvoltage_trip(overvoltage_trip),
    .overvoltage_clear(overvoltage_clear),
    .brightness_code(brightness_code),
    .boost_switch_enable(boost_switch_enable));
  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string name, input logic [4:0] exp,
                     input logic [4:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wait_ready(input logic lvl);
    int n;
    n = 0;
    while (send_ready !== lvl && n < 120000) begin
      @(posedge clk_sys);
      n++;
    end
    if (send_ready !== lvl) begin
      err_total++;
      close_out();
    end
  endtask : wait_ready
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  task automatic run_frame();
    wait_ready(1'b1);
    chk("idle", 5'h01, {4'h0, dim_link_if_i.serial_dim_in});
    send_code <= 5'h1d;
    send_valid <= 1'b1;
    step(1);
    send_valid <= 1'b0;
    wait_ready(1'b0);
    wait_ready(1'b1);
    step(2);
    chk("code", 5'h1d, brightness_code);
  endtask : run_frame
  task automatic run_ovp();
    overvoltage_trip <= 1'b1;
    overvoltage_clear <= 1'b0;
    step(3);
    chk("boost_trip", 5'h00, {4'h0, boost_switch_enable});
    chk("code_trip", 5'h1d, brightness_code);
    chk("power_trip", 5'h01, {4'h0, powered_on});
    overvoltage_trip <= 1'b0;
    step(3);
    chk("boost_hyst", 5'h00, {4'h0, boost_switch_enable});
    overvoltage_clear <= 1'b1;
    step(3);
    chk("boost_back", 5'h01, {4'h0, boost_switch_enable});
  endtask : run_ovp
  task automatic run_off();
    enable_req <= 1'b0;
    step(3);
    chk("power_off", 5'h00, {4'h0, powered_on});
    chk("code_off", 5'h00, brightness_code);
    enable_req <= 1'b1;
    step(4);
    chk("power_on", 5'h01, {4'h0, powered_on});
    chk("code_on", 5'h00, brightness_code);
    undervoltage_lockout <= 1'b1;
    step(3);
    chk("code_undervoltage_lockout", 5'h00, brightness_code);
    chk("boost_undervoltage_lockout", 5'h00, {4'h0, boost_switch_enable});
    undervoltage_lockout <= 1'b0;
    step(3);
    chk("boost_on", 5'h01, {4'h0, boost_switch_enable});
  endtask : run_off
  initial begin
    step(5);
    rst <= 1'b0;
    run_frame();
    run_ovp();
    run_off();
    close_out();
  end
endmodule : testbench
